// *** core/tmr_map.vh ***
// Register offsets, field positions, reset values and timing counts of the timer.
`ifndef TMR_MAP_VH
`define TMR_MAP_VH
`define TMR_ADDR_CTRL    5'h00
`define TMR_ADDR_CNT     5'h04
`define TMR_ADDR_OCR     5'h08
`define TMR_ADDR_STAT    5'h0C
`define TMR_ADDR_GTC     5'h10
`define TMR_ADDR_MASK    5'h14
`define TMR_ADDR_FLAG    5'h18
`define TMR_ADDR_SLEEP   5'h1C
`define TMR_CTRL_FORCE   7
`define TMR_CTRL_WGM0    6
`define TMR_CTRL_COM1    5
`define TMR_CTRL_COM0    4
`define TMR_CTRL_WGM1    3
`define TMR_STAT_EXT     4
`define TMR_STAT_ASYNC   3
`define TMR_STAT_CNT_UB  2
`define TMR_STAT_OCR_UB  1
`define TMR_STAT_CTL_UB  0
`define TMR_GTC_PSR      0
`define TMR_BIT_CMP      1
`define TMR_BIT_OVF      0
`define TMR_SLEEP_GO     0
`define TMR_MODE_NORMAL  2'h0
`define TMR_MODE_PC      2'h1
`define TMR_MODE_CTC     2'h2
`define TMR_MODE_FAST    2'h3
`define TMR_SLP_PDOWN    3'h2
`define TMR_SLP_STANDBY  3'h6
`define TMR_RST_BYTE     8'h00
`define TMR_MAX          8'hFF
`define TMR_BOTTOM       8'h00
`define TMR_XFER_EDGES   2'h2
`define TMR_HALT_CYCLES  3'h4
`define TMR_RESP_OKAY    2'h0
`define TMR_RESP_SLVERR  2'h2
`endif

// *** core/tmr_top.v ***
// Eight-bit timer with prescaler, asynchronous clocking and AXI4-Lite registers.
//
// Overview of operation
// R1: Phase-correct period is 510 timer ticks times prescale factor N.
// R2: Compare at BOTTOM gives constant low, at MAX constant high; inverted opposite.
// R3: Leaving MAX, output at MAX takes the up-count match level.
// R4: Starting above compare still yields the symmetric transition without a match.
// R5: Timer clock is an enable on aclk; oscillator edges replace it when asynchronous.
// R6: Asynchronous writes held, latched after two oscillator rising edges; no rewrite meanwhile.
// R7: Counter, compare and control each have their own holding register.
// R8: Compare matches suppressed while counter or compare write is pending.
// R9: Busy flag set on write, cleared when value reaches destination.
// R10: After wake-up, one oscillator cycle before another wake-up can occur.
// R11: Asynchronous wake-up starts on the following timer clock cycle.
// R12: After wake-up the processor halts four cycles, then takes the interrupt.
// R13: Counter reads go through a register refreshed on each oscillator rising edge.
// R14: Asynchronous flag sync takes three processor cycles plus one timer cycle.
// R15: Compare output changes on the timer clock, not resynchronised.
// R16: Default clock is aclk; async select uses oscillator and releases both pins.
// R17: Software sets external clock enable when a clock, not crystal, drives the pin.
// R18: Prescaler offers undivided, 8, 32, 64, 128, 256, 1024 and stopped.
// R19: Writing one to prescaler reset restarts the prescaler.
// R20: Software follows safe sequence when switching clock source.
// R21: After power-save, software writes then waits busy clear before reading counter.
// R22: Oscillator runs in all sleep modes except power-down and standby.
// R23: Non-inverting phase-correct clears on up match and sets on down match.
// R24: Phase-correct counter reverses at MAX without holding; the next timer tick takes it to 254.
// R25: Phase-correct overflow flag set each time the counter reaches BOTTOM.
// R26: Software access only on aclk; holding registers are the only path to oscillator timing.
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "tmr_map.vh"

module tmr_hold (
   // Clock and reset.
   input  wire       clk,
   input  wire       rstn,
   // Write side.
   input  wire       async_mode,
   input  wire       wr,
   input  wire [7:0] wdata,
   input  wire       osc_tick,
   // Transfer side.
   output reg  [7:0] data_reg,
   output reg        busy_reg,
   output reg        commit_reg
);
   reg [1:0] edges_reg;

   always @(posedge clk) begin
      if (!rstn) begin
         data_reg   <= `TMR_RST_BYTE;
         busy_reg   <= 1'b0;
         commit_reg <= 1'b0;
         edges_reg  <= 2'h0;
      end else begin
         commit_reg <= 1'b0;
         if (wr) begin
            data_reg <= wdata;
            if (async_mode) begin
               busy_reg  <= 1'b1; // R9
               edges_reg <= 2'h0;
            end else begin
               commit_reg <= 1'b1;
            end
         end else if (busy_reg && osc_tick) begin
            edges_reg <= edges_reg + 2'h1;
            if (edges_reg == `TMR_XFER_EDGES - 2'h1) begin
               busy_reg   <= 1'b0; // R9
               commit_reg <= 1'b1; // R6
            end
         end
      end
   end
endmodule // tmr_hold

module tmr_top (
   // Clock and reset.
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address.
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data.
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response.
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address.
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data.
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Oscillator pins.
   input  wire        osc_in_pin,
   output reg         osc_pins_released,
   output reg         osc_amp_enable,
   output reg         ext_clock_buffer_enable,
   // Waveform output.
   output reg         compare_output,
   output reg         compare_output_enable,
   // Processor side.
   output reg         timer_irq,
   output reg         wake_req,
   output reg         cpu_halt
);
   reg        osc_meta_reg;
   reg        osc_sync_reg;
   reg        osc_prev_reg;
   reg        osc_run_reg;
   reg        async_reg;
   reg        ext_reg;
   reg [6:0]  ctrl_reg;
   reg [7:0]  cnt_reg;
   reg [7:0]  cnt_rd_reg;
   reg [7:0]  ocr_reg;
   reg [7:0]  ocr_act_reg;
   reg        dir_reg;
   reg        block_reg;
   reg [9:0]  pre_reg;
   reg [1:0]  mask_reg;
   reg [1:0]  flag_reg;
   reg [2:0]  cmp_pipe_reg;
   reg [2:0]  ovf_pipe_reg;
   reg        sleeping_reg;
   reg [2:0]  slp_mode_reg;
   reg        wake_pend_reg;
   reg        armed_reg;
   reg [2:0]  halt_cnt_reg;
   reg        aw_got_reg;
   reg        w_got_reg;
   reg [4:0]  awaddr_reg;
   reg [7:0]  wbyte_reg;
   reg        wlane_reg;
   reg [31:0] rd_mux;
   reg        rd_ok;
   reg        wr_ok;
   reg        tick;
   reg [7:0]  cnt_next;
   reg        dir_next;
   reg [7:0]  ocr_next;
   reg        lvl;
   wire       osc_tick;
   wire       src_tick;
   wire       wr_fire;
   wire       wr_lane;
   wire       ctl_wr;
   wire       cnt_wr;
   wire       ocr_wr;
   wire [7:0] ctl_hold;
   wire [7:0] cnt_hold;
   wire [7:0] ocr_hold;
   wire       ctl_busy;
   wire       cnt_busy;
   wire       ocr_busy;
   wire       ctl_commit;
   wire       cnt_commit;
   wire       ocr_commit;
   wire [1:0] wgm;
   wire       pwm;
   wire       match;
   wire       cmp_ev;
   wire       ovf_ev;
   wire [1:0] flag_set;
   wire       irq_cond;
   wire       wake_now;

   assign osc_tick = osc_sync_reg & ~osc_prev_reg & osc_run_reg;
   assign src_tick = async_reg ? osc_tick : 1'b1; // R5 R16
   assign wgm      = {ctrl_reg[`TMR_CTRL_WGM1], ctrl_reg[`TMR_CTRL_WGM0]};
   assign pwm      = (wgm == `TMR_MODE_PC) || (wgm == `TMR_MODE_FAST);
   assign wr_fire  = aw_got_reg & w_got_reg & ~s_axi_bvalid;
   assign wr_lane  = wr_fire & wlane_reg;
   assign ctl_wr   = wr_lane && (awaddr_reg == `TMR_ADDR_CTRL);
   assign cnt_wr   = wr_lane && (awaddr_reg == `TMR_ADDR_CNT);
   assign ocr_wr   = wr_lane && (awaddr_reg == `TMR_ADDR_OCR);

   // Oscillator pin synchroniser and edge detector.
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_meta_reg <= 1'b0;
         osc_sync_reg <= 1'b0;
         osc_prev_reg <= 1'b0;
      end else begin
         osc_meta_reg <= osc_in_pin;
         osc_sync_reg <= osc_meta_reg;
         osc_prev_reg <= osc_sync_reg;
      end
   end

   // Holding registers, one per destination.
   tmr_hold u_hold_ctl (
      .clk        (aclk),
      .rstn       (aresetn),
      .async_mode (async_reg),
      .wr         (ctl_wr),
      .wdata      (wbyte_reg),
      .osc_tick   (osc_tick),
      .data_reg   (ctl_hold),
      .busy_reg   (ctl_busy),
      .commit_reg (ctl_commit)
   ); // R7 R26
   tmr_hold u_hold_cnt (
      .clk        (aclk),
      .rstn       (aresetn),
      .async_mode (async_reg),
      .wr         (cnt_wr),
      .wdata      (wbyte_reg),
      .osc_tick   (osc_tick),
      .data_reg   (cnt_hold),
      .busy_reg   (cnt_busy),
      .commit_reg (cnt_commit)
   ); // R7
   tmr_hold u_hold_ocr (
      .clk        (aclk),
      .rstn       (aresetn),
      .async_mode (async_reg),
      .wr         (ocr_wr),
      .wdata      (wbyte_reg),
      .osc_tick   (osc_tick),
      .data_reg   (ocr_hold),
      .busy_reg   (ocr_busy),
      .commit_reg (ocr_commit)
   ); // R7

   // Prescaler and clock select.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pre_reg <= 10'h000;
      end else if (wr_lane && (awaddr_reg == `TMR_ADDR_GTC) &&
                   wbyte_reg[`TMR_GTC_PSR]) begin
         pre_reg <= 10'h000; // R19
      end else if (src_tick) begin
         pre_reg <= pre_reg + 10'h001;
      end
   end

   always @* begin
      case (ctrl_reg[2:0])
         3'h0: tick = 1'b0;
         3'h1: tick = src_tick;
         3'h2: tick = src_tick & (&pre_reg[2:0]);
         3'h3: tick = src_tick & (&pre_reg[4:0]);
         3'h4: tick = src_tick & (&pre_reg[5:0]);
         3'h5: tick = src_tick & (&pre_reg[6:0]);
         3'h6: tick = src_tick & (&pre_reg[7:0]);
         default: tick = src_tick & (&pre_reg[9:0]);
      endcase // R18
   end

   // Next count, direction and active compare value.
   always @* begin
      cnt_next = cnt_reg + 8'h01;
      dir_next = dir_reg;
      case (wgm)
         `TMR_MODE_PC: begin
            if (dir_reg) begin
               if (cnt_reg == `TMR_MAX) begin
                  dir_next = 1'b0; // R24
                  cnt_next = cnt_reg - 8'h01;
               end
            end else if (cnt_reg == `TMR_BOTTOM) begin
               dir_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         `TMR_MODE_CTC: begin
            if (cnt_reg == ocr_act_reg)
               cnt_next = `TMR_BOTTOM;
         end
         default: cnt_next = cnt_reg + 8'h01;
      endcase
      ocr_next = ocr_act_reg;
      if (!pwm ||
          ((wgm == `TMR_MODE_PC) && (cnt_next == `TMR_MAX)) ||
          ((wgm == `TMR_MODE_FAST) && (cnt_next == `TMR_BOTTOM)))
         ocr_next = ocr_reg;
      if (wgm == `TMR_MODE_PC)
         lvl = (ocr_next == `TMR_MAX) || (cnt_next < ocr_next); // R2 R3 R4 R23
      else
         lvl = (cnt_next <= ocr_next);
   end

   assign match  = (cnt_reg == ocr_act_reg) & ~block_reg & ~cnt_busy & ~ocr_busy; // R8
   assign cmp_ev = tick & match;
   assign ovf_ev = tick & (cnt_next == `TMR_BOTTOM) &
                   ((wgm == `TMR_MODE_PC) || (cnt_reg == `TMR_MAX)); // R25

   // Counter, waveform and control destination registers.
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg       <= 7'h00;
         cnt_reg        <= `TMR_RST_BYTE;
         ocr_reg        <= `TMR_RST_BYTE;
         ocr_act_reg    <= `TMR_RST_BYTE;
         dir_reg        <= 1'b1;
         block_reg      <= 1'b0;
         compare_output <= 1'b0;
      end else begin
         if (ocr_commit)
            ocr_reg <= ocr_hold;
         if (ctl_commit)
            ctrl_reg <= ctl_hold[6:0];
         if (cnt_commit) begin
            cnt_reg   <= cnt_hold;
            block_reg <= 1'b1;
         end else if (tick) begin
            cnt_reg     <= cnt_next; // R1
            dir_reg     <= dir_next;
            ocr_act_reg <= ocr_next;
            block_reg   <= 1'b0;
         end
         if (tick && pwm && ctrl_reg[`TMR_CTRL_COM1]) begin
            compare_output <= lvl ^ ctrl_reg[`TMR_CTRL_COM0]; // R2 R15
         end else if (!pwm && (cmp_ev ||
                      (ctl_commit && ctl_hold[`TMR_CTRL_FORCE]))) begin
            case (ctrl_reg[5:4])
               2'h1: compare_output <= ~compare_output;
               2'h2: compare_output <= 1'b0;
               2'h3: compare_output <= 1'b1;
               default: compare_output <= compare_output;
            endcase // R15
         end
      end
   end

   // Counter readback, flags and their synchronisation delay.
   assign flag_set[`TMR_BIT_CMP] = async_reg ? cmp_pipe_reg[2] : cmp_ev; // R14
   assign flag_set[`TMR_BIT_OVF] = async_reg ? ovf_pipe_reg[2] : ovf_ev; // R14
   assign irq_cond = |(flag_reg & mask_reg);
   assign wake_now = wake_pend_reg & (osc_tick | ~async_reg); // R11

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_rd_reg   <= `TMR_RST_BYTE;
         cmp_pipe_reg <= 3'h0;
         ovf_pipe_reg <= 3'h0;
         flag_reg     <= 2'h0;
         mask_reg     <= 2'h0;
      end else begin
         if (!async_reg || osc_tick)
            cnt_rd_reg <= cnt_reg; // R13
         cmp_pipe_reg <= {cmp_pipe_reg[1:0], cmp_ev};
         ovf_pipe_reg <= {ovf_pipe_reg[1:0], ovf_ev};
         if (wr_lane && (awaddr_reg == `TMR_ADDR_MASK))
            mask_reg <= wbyte_reg[1:0];
         if (wr_lane && (awaddr_reg == `TMR_ADDR_FLAG))
            flag_reg <= flag_set | (flag_reg & ~wbyte_reg[1:0]);
         else
            flag_reg <= flag_set | flag_reg;
      end
   end

   // Clock source, sleep and wake-up control.
   always @(posedge aclk) begin
      if (!aresetn) begin
         async_reg               <= 1'b0;
         ext_reg                 <= 1'b0;
         osc_run_reg             <= 1'b0;
         osc_pins_released       <= 1'b0;
         osc_amp_enable          <= 1'b0;
         ext_clock_buffer_enable <= 1'b0;
         compare_output_enable   <= 1'b0;
         sleeping_reg            <= 1'b0;
         slp_mode_reg            <= 3'h0;
         wake_pend_reg           <= 1'b0;
         armed_reg               <= 1'b1;
         halt_cnt_reg            <= 3'h0;
         wake_req                <= 1'b0;
         cpu_halt                <= 1'b0;
         timer_irq               <= 1'b0;
      end else begin
         if (wr_lane && (awaddr_reg == `TMR_ADDR_STAT)) begin
            async_reg <= wbyte_reg[`TMR_STAT_ASYNC];
            ext_reg   <= wbyte_reg[`TMR_STAT_EXT];
         end
         osc_run_reg <= async_reg & ~(sleeping_reg &
                        ((slp_mode_reg == `TMR_SLP_PDOWN) ||
                         (slp_mode_reg == `TMR_SLP_STANDBY))); // R22
         osc_pins_released       <= async_reg; // R16
         osc_amp_enable          <= async_reg & osc_run_reg & ~ext_reg;
         ext_clock_buffer_enable <= async_reg & osc_run_reg & ext_reg;
         compare_output_enable   <= |ctrl_reg[5:4];
         if (!async_reg || osc_tick)
            armed_reg <= 1'b1; // R10
         wake_req <= 1'b0;
         if (wake_now) begin
            sleeping_reg  <= 1'b0;
            wake_pend_reg <= 1'b0;
            armed_reg     <= 1'b0; // R10
            wake_req      <= 1'b1;
            halt_cnt_reg  <= `TMR_HALT_CYCLES; // R12
            cpu_halt      <= 1'b1;
         end else begin
            if (wr_lane && (awaddr_reg == `TMR_ADDR_SLEEP) &&
                wbyte_reg[`TMR_SLEEP_GO]) begin
               sleeping_reg <= 1'b1;
               slp_mode_reg <= wbyte_reg[3:1];
            end
            if (sleeping_reg && armed_reg && irq_cond)
               wake_pend_reg <= 1'b1;
            if (halt_cnt_reg != 3'h0) begin
               halt_cnt_reg <= halt_cnt_reg - 3'h1;
               cpu_halt     <= (halt_cnt_reg != 3'h1); // R12
            end
         end
         timer_irq <= irq_cond & ~cpu_halt & ~sleeping_reg;
      end
   end

   // Read data selection.
   always @* begin
      rd_mux = 32'h00000000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         `TMR_ADDR_CTRL:  rd_mux[6:0] = ctrl_reg;
         `TMR_ADDR_CNT:   rd_mux[7:0] = cnt_rd_reg; // R13
         `TMR_ADDR_OCR:   rd_mux[7:0] = ocr_reg;
         `TMR_ADDR_STAT:  rd_mux[4:0] = {ext_reg, async_reg,
                                         cnt_busy, ocr_busy, ctl_busy}; // R9
         `TMR_ADDR_GTC:   rd_mux = 32'h00000000;
         `TMR_ADDR_MASK:  rd_mux[1:0] = mask_reg;
         `TMR_ADDR_FLAG:  rd_mux[1:0] = flag_reg;
         `TMR_ADDR_SLEEP: rd_mux[3:0] = {slp_mode_reg, sleeping_reg};
         default:         rd_ok = 1'b0;
      endcase
   end

   always @* begin
      case (awaddr_reg)
         `TMR_ADDR_CTRL, `TMR_ADDR_CNT, `TMR_ADDR_OCR, `TMR_ADDR_STAT,
         `TMR_ADDR_GTC, `TMR_ADDR_MASK, `TMR_ADDR_FLAG,
         `TMR_ADDR_SLEEP: wr_ok = 1'b1;
         default:         wr_ok = 1'b0;
      endcase
   end

   // AXI4-Lite write channels.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `TMR_RESP_OKAY;
         aw_got_reg    <= 1'b0;
         w_got_reg     <= 1'b0;
         awaddr_reg    <= 5'h00;
         wbyte_reg     <= `TMR_RST_BYTE;
         wlane_reg     <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg    <= 1'b1;
            awaddr_reg    <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_got_reg && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg    <= 1'b1;
            wbyte_reg    <= s_axi_wdata[7:0];
            wlane_reg    <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end else if (!w_got_reg && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channels.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `TMR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end
endmodule // tmr_top

// *** verif/tmr_checker.sv ***
// Port-level assertions for the timer block.
`timescale 1ns/1ps
module tmr_checker (
   // Clock and reset.
   input logic aclk,
   input logic aresetn,
   // Bus handshakes.
   input logic s_axi_awready,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // Oscillator pins.
   input logic osc_pins_released,
   input logic osc_amp_enable,
   input logic ext_clock_buffer_enable,
   // Processor side.
   input logic timer_irq,
   input logic wake_req,
   input logic cpu_halt
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Four halted cycles and then release.
   sequence s_halt4;
      cpu_halt [*4] ##1 !cpu_halt;
   endsequence
   property p_halt_len; wake_req |-> s_halt4; endproperty
   a_halt_len: assert property (p_halt_len) else $error("halt length wrong");
   property p_halt_start; $rose(cpu_halt) |-> wake_req; endproperty
   a_halt_start: assert property (p_halt_start) else $error("halt without wake");
   property p_irq_quiet; cpu_halt && $past(cpu_halt) |-> !timer_irq; endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq during halt");
   property p_wake_pulse; wake_req |=> !wake_req; endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");
   property p_amp; osc_amp_enable |-> osc_pins_released && !ext_clock_buffer_enable; endproperty
   a_amp: assert property (p_amp) else $error("crystal amplifier misuse");
   property p_ext; ext_clock_buffer_enable |-> osc_pins_released; endproperty
   a_ext: assert property (p_ext) else $error("external buffer without release");
   property p_b_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_b_refuse: assert property (p_b_refuse) else $error("write taken during response");
   property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_done: assert property (p_r_done) else $error("read data not released");
   property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_done: assert property (p_b_done) else $error("write response not released");
endmodule // tmr_checker

bind tmr_top tmr_checker chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .osc_pins_released, .osc_amp_enable, .ext_clock_buffer_enable, .timer_irq, .wake_req,
   .cpu_halt);

// *** verif/tmr_tb_top.sv ***
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`include "tmr_map.vh"
module tmr_tb_top;
   // Clock, reset and oscillator.
   logic        aclk = 1'b0, aresetn = 1'b0, osc_in_pin = 1'b0;
   // Bus requests.
   logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0, q;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   // Design outputs.
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        osc_pins_released, osc_amp_enable, ext_clock_buffer_enable;
   logic        compare_output, compare_output_enable, timer_irq, wake_req, cpu_halt;
   // Bench state.
   int          i, c, n, e, d, bad_count = 0, check_count = 0, osc_edges = 0;
   int          nt[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
   logic [1:0]  br, rr;

   tmr_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .osc_in_pin, .osc_pins_released, .osc_amp_enable,
      .ext_clock_buffer_enable, .compare_output, .compare_output_enable, .timer_irq,
      .wake_req, .cpu_halt);

   always #25 aclk = ~aclk;
   always #500 osc_in_pin = ~osc_in_pin;
   always @(posedge osc_in_pin) osc_edges++;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      q = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
      rd(a);
      chk(q & m, v);
      chk(32'(rr), 32'(`TMR_RESP_OKAY));
   endtask

   // Counts high cycles over one period and compares with the modelled duty.
   task automatic pwm(input logic [7:0] ctl, input int cv, input int inv, input int k);
      int hi;
      int h;
      hi = 0;
      wr(`TMR_ADDR_OCR, cv[7:0]);
      wr(`TMR_ADDR_CTRL, ctl);
      repeat (510 * k + 40) @(posedge aclk);
      repeat (510 * k) begin
         @(posedge aclk);
         hi += (compare_output === 1'b1);
      end
      h = (cv == 255) ? 510 : (cv == 0) ? 0 : 2 * cv - 1;
      chk(hi, (inv ? 510 - h : h) * k);
      chk(32'(compare_output_enable), 32'h1);
      $display("pwm test done c=%0d inv=%0d n=%0d", cv, inv, k);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #4000000;
      bad_count++;
      give_verdict;
   end

   initial begin
      void'($urandom(32'h08f76a00));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 8; i++) rchk(5'(4 * i), 32'hFFFFFFFF, 32'h0);
      rd(5'h01);
      chk(32'(rr), 32'(`TMR_RESP_SLVERR));
      wr(5'h02, 8'h00);
      chk(32'(br), 32'(`TMR_RESP_SLVERR));
      $display("reset test done");
      for (i = 0; i < 8; i++) begin
         wr(`TMR_ADDR_CTRL, 8'(i));
         wr(`TMR_ADDR_GTC, 8'h01);
         wr(`TMR_ADDR_CNT, 8'h00);
         repeat (2040) @(posedge aclk);
         rd(`TMR_ADDR_CNT);
         d = (int'(q[7:0]) - ((nt[i] == 0) ? 0 : 2040 / nt[i])) & 255;
         chk(32'(d <= 4 || d >= 252), 32'h1);
      end
      rchk(`TMR_ADDR_GTC, 32'hFF, 32'h0);
      $display("prescaler test done");
      for (i = 0; i < 6; i++) begin
         c = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 255 : $urandom_range(254, 1);
         pwm((i < 3) ? 8'h61 : 8'h71, c, i / 3, 1);
      end
      pwm(8'h62, $urandom_range(254, 1), 0, 8);
      wr(`TMR_ADDR_FLAG, 8'h03);
      wr(`TMR_ADDR_MASK, 8'h01);
      wr(`TMR_ADDR_SLEEP, 8'h01);
      n = 0;
      while (wake_req !== 1'b1 && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(n < 5000), 32'h1);
      n = 0;
      repeat (8) begin
         n += (cpu_halt === 1'b1);
         @(posedge aclk);
      end
      chk(n, 4);
      chk(32'(timer_irq), 32'h1);
      rchk(`TMR_ADDR_FLAG, 32'h1, 32'h1);
      wr(`TMR_ADDR_MASK, 8'h00);
      @(posedge aclk);
      chk(32'(timer_irq), 32'h0);
      $display("wake test done");
      wr(`TMR_ADDR_STAT, 8'h08);
      repeat (100) @(posedge aclk);
      chk(32'(osc_pins_released), 32'h1);
      chk(32'(osc_amp_enable), 32'h1);
      e = osc_edges;
      wr(`TMR_ADDR_CNT, 8'h10);
      wr(`TMR_ADDR_OCR, 8'h5A);
      wr(`TMR_ADDR_CTRL, 8'h61);
      rchk(`TMR_ADDR_STAT, 32'h7, 32'h7);
      n = 0;
      do begin
         rd(`TMR_ADDR_STAT);
         n++;
      end while (q[2:0] !== 3'h0 && n < 500);
      chk(32'(osc_edges - e >= 2 && osc_edges - e <= 5 && n < 500), 32'h1);
      rchk(`TMR_ADDR_OCR, 32'hFF, 32'h5A);
      wr(`TMR_ADDR_OCR, 8'h5A);
      do rd(`TMR_ADDR_STAT); while (q[`TMR_STAT_OCR_UB] !== 1'b0);
      rd(`TMR_ADDR_CNT);
      d = (int'(q[7:0]) - 16) & 255;
      chk(32'(d <= 8 || d >= 248), 32'h1);
      wr(`TMR_ADDR_STAT, 8'h18);
      repeat (100) @(posedge aclk);
      chk(32'(ext_clock_buffer_enable), 32'h1);
      chk(32'(osc_amp_enable), 32'h0);
      $display("async test done");
      give_verdict;
   end
endmodule // tmr_tb_top
